/* common/dtc_consts.vh */
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// ****************************************
// register indexes (byte address = 4 * index)
// ****************************************
`define DTC_IDX_RUN_FLAGS 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_T0_LOW 8'h8A
`define DTC_IDX_T1_LOW 8'h8B
`define DTC_IDX_T0_HIGH 8'h8C
`define DTC_IDX_T1_HIGH 8'h8D
`define DTC_IDX_PRESCALE 8'h8E

// ****************************************
// field positions
// ****************************************
`define DTC_BIT_GATE1 7
`define DTC_BIT_SRC1 6
`define DTC_BIT_MODE1_HI 5
`define DTC_BIT_MODE1_LO 4
`define DTC_BIT_GATE0 3
`define DTC_BIT_SRC0 2
`define DTC_BIT_MODE0_HI 1
`define DTC_BIT_MODE0_LO 0
`define DTC_BIT_OVF1 7
`define DTC_BIT_RUN1 6
`define DTC_BIT_OVF0 5
`define DTC_BIT_RUN0 4
`define DTC_BIT_PRESC1 4
`define DTC_BIT_PRESC0 3
`define DTC_PRESCALE_MASK 8'h18
`define DTC_RUN_FLAGS_MASK 8'hF0

// ****************************************
// mode codes, reset values, divisors
// ****************************************
`define DTC_MODE_13BIT 2'b00
`define DTC_MODE_16BIT 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11
`define DTC_RST_BYTE 8'h00
`define DTC_DIV_SLOW 12
`define DTC_DIV_FAST 6

`endif

/* rtl/dtc_tick_gen.v */
`timescale 1ns/1ps
`include "dtc_consts.vh"

// ****************************************
// prescale tick: one-cycle enable every 12 or 6 clocks
// ****************************************
module dtc_tick_gen #(
  parameter DIV_SLOW = `DTC_DIV_SLOW,
  parameter DIV_FAST = `DTC_DIV_FAST,
  parameter CNT_W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire fast_i,
  output reg tick_o
);
  // end points worked out wide, then cut to the counter width on purpose
  localparam integer LAST_SLOW_I = DIV_SLOW - 1;
  localparam integer LAST_FAST_I = DIV_FAST - 1;
  localparam [CNT_W-1:0] LAST_SLOW = LAST_SLOW_I[CNT_W-1:0];
  localparam [CNT_W-1:0] LAST_FAST = LAST_FAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] last = fast_i ? LAST_FAST : LAST_SLOW;

  // >= so a switch to the short divide mid-count never overruns
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= {CNT_W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

/* rtl/dtc_timer.v */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "dtc_consts.vh"

// How it works
// (R1) timer 0 gated: counts only while its irq pin high and run bit set
// (R2) timer 0 source bit: clear counts prescaled clock, set counts count-pin falls
// (R3) mode register: timer 0 mode in bits 1:0, timer 1 in bits 5:4
// (R4) code 00: high byte 8-bit counter behind 5-bit low-byte prescaler
// (R5) code 01: full 16-bit counter of high and low bytes
// (R6) code 10: low byte counts, reloads from high byte on overflow
// (R7) code 11: timer 0 low byte is 8-bit counter under timer 0 controls
// (R8) code 11: timer 0 high byte counts internal clock, run by timer 1 bit
// (R9) timer 1 in code 11 stops and holds its count
// (R10) timer 0 internal clock is clock/12, or clock/6 with its prescale bit
// (R11) timer 1 internal clock is clock/12, or clock/6 with its prescale bit
// (R12) timer 1 gating and source select mirror timer 0 using its own pins
// (R13) each timer has a software run bit that starts and stops it
// (R14) overflow sets flag; vectoring clears it; software may set or clear
// (R15) in split mode timer 0 high-byte overflow sets timer 1 flag
module dtc_timer #(
  parameter ADDR_W = 10
) (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  input wire EXT_IRQ_PIN_ZERO_I,
  input wire EXT_IRQ_PIN_ONE_I,
  input wire COUNT_PIN_ZERO_I,
  input wire COUNT_PIN_ONE_I,
  input wire TIMER0_VECTOR_I,
  input wire TIMER1_VECTOR_I,
  output reg TIMER0_OVERFLOW_FLAG_O,
  output reg TIMER1_OVERFLOW_FLAG_O
);

  // ****************************************
  // functions
  // ****************************************

  // register index decode, shared by the write and read paths
  function hit;
    input [ADDR_W-1:0] addr;
    input [7:0] idx;
    reg [ADDR_W-1:0] want;
    begin
      want = {ADDR_W{1'b0}};
      // byte address is four times the index, low two bits zero
      want[9:2] = idx;
      hit = (addr == want);
    end
  endfunction

  // falling edge of a synchronous pin: high last sample, low now
  function pin_fall;
    input prev;
    input cur;
    begin
      pin_fall = prev & ~cur;
    end
  endfunction

  // one counting step: {overflow, high, low}
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    input inc;
    reg [13:0] s13;
    reg [16:0] s16;
    reg [8:0] s8;
    begin
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8 = {1'b0, lo} + 9'h001;
      dtc_step = {1'b0, hi, lo};
      if (inc) begin
        case (mode)
          // 13-bit: low[7:5] ride along untouched
          `DTC_MODE_13BIT: dtc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // [R4]
          // 16-bit: carry runs from low into high
          `DTC_MODE_16BIT: dtc_step = s16; // [R5]
          // reload: high byte is the reload value and never counts
          `DTC_MODE_RELOAD: dtc_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])}; // [R6]
          // split: low byte alone; the high byte has its own path
          default: dtc_step = {s8[8], hi, s8[7:0]}; // [R7]
        endcase
      end
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] mode_reg;
  reg [7:0] prescale_reg;
  reg run0_reg;
  reg run1_reg;
  reg [7:0] t0_low_reg;
  reg [7:0] t0_high_reg;
  reg [7:0] t1_low_reg;
  reg [7:0] t1_high_reg;
  reg cnt0_prev_reg;
  reg cnt1_prev_reg;
  reg [7:0] t0_low_next;
  reg [7:0] t0_high_next;
  reg [7:0] t1_low_next;
  reg [7:0] t1_high_next;
  reg ovf0_next;
  reg ovf1_next;

  wire tick0;
  wire tick1;

  // ****************************************
  // apb slave: one wait state, pready from a flop
  // ****************************************
  wire access = PSEL_I & PENABLE_I;
  wire wr_now = access & PREADY_O & PWRITE_I;
  wire wr_run = wr_now & hit(PADDR_I, `DTC_IDX_RUN_FLAGS);
  wire wr_mode = wr_now & hit(PADDR_I, `DTC_IDX_MODE);
  wire wr_t0l = wr_now & hit(PADDR_I, `DTC_IDX_T0_LOW);
  wire wr_t1l = wr_now & hit(PADDR_I, `DTC_IDX_T1_LOW);
  wire wr_t0h = wr_now & hit(PADDR_I, `DTC_IDX_T0_HIGH);
  wire wr_t1h = wr_now & hit(PADDR_I, `DTC_IDX_T1_HIGH);
  wire wr_psc = wr_now & hit(PADDR_I, `DTC_IDX_PRESCALE);

  wire mapped = hit(PADDR_I, `DTC_IDX_RUN_FLAGS) | hit(PADDR_I, `DTC_IDX_MODE) |
                hit(PADDR_I, `DTC_IDX_T0_LOW) | hit(PADDR_I, `DTC_IDX_T1_LOW) |
                hit(PADDR_I, `DTC_IDX_T0_HIGH) | hit(PADDR_I, `DTC_IDX_T1_HIGH) |
                hit(PADDR_I, `DTC_IDX_PRESCALE);

  wire [7:0] run_flags_view = {TIMER1_OVERFLOW_FLAG_O, run1_reg,
                               TIMER0_OVERFLOW_FLAG_O, run0_reg, 4'h0};

  reg [7:0] rd_byte;

  // read mux, narrow registers in the low byte
  always @* begin
    rd_byte = 8'h00;
    if (hit(PADDR_I, `DTC_IDX_RUN_FLAGS)) rd_byte = run_flags_view;
    if (hit(PADDR_I, `DTC_IDX_MODE)) rd_byte = mode_reg;
    if (hit(PADDR_I, `DTC_IDX_T0_LOW)) rd_byte = t0_low_reg;
    if (hit(PADDR_I, `DTC_IDX_T1_LOW)) rd_byte = t1_low_reg;
    if (hit(PADDR_I, `DTC_IDX_T0_HIGH)) rd_byte = t0_high_reg;
    if (hit(PADDR_I, `DTC_IDX_T1_HIGH)) rd_byte = t1_high_reg;
    if (hit(PADDR_I, `DTC_IDX_PRESCALE)) rd_byte = prescale_reg;
  end

  // answer in the second access cycle; data captured with it
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end else if (access & ~PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= ~mapped;
      PRDATA_O <= PWRITE_I ? 32'h00000000 : {24'h000000, rd_byte};
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // ****************************************
  // prescale dividers
  // ****************************************
  wire [1:0] fast_sel = {prescale_reg[`DTC_BIT_PRESC1], prescale_reg[`DTC_BIT_PRESC0]}; // [R10] [R11]
  wire [1:0] tick_vec;
  genvar gi;

  // one divider per timer, each with its own prescale select
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tick
      dtc_tick_gen u_tick (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .fast_i(fast_sel[gi]),
        .tick_o(tick_vec[gi])
      );
    end
  endgenerate

  assign tick0 = tick_vec[0];
  assign tick1 = tick_vec[1];

  // ****************************************
  // count enables
  // ****************************************
  wire [1:0] mode0 = mode_reg[`DTC_BIT_MODE0_HI:`DTC_BIT_MODE0_LO]; // [R3]
  wire [1:0] mode1 = mode_reg[`DTC_BIT_MODE1_HI:`DTC_BIT_MODE1_LO]; // [R3]
  wire split0 = (mode0 == `DTC_MODE_SPLIT);

  // pins are synchronous; a fall is last sample high, now low
  wire fall0 = pin_fall(cnt0_prev_reg, COUNT_PIN_ZERO_I);
  wire fall1 = pin_fall(cnt1_prev_reg, COUNT_PIN_ONE_I);

  wire go0 = run0_reg & (~mode_reg[`DTC_BIT_GATE0] | EXT_IRQ_PIN_ZERO_I); // [R1] [R13]
  wire go1 = run1_reg & (~mode_reg[`DTC_BIT_GATE1] | EXT_IRQ_PIN_ONE_I); // [R12] [R13]
  wire inc0 = go0 & (mode_reg[`DTC_BIT_SRC0] ? fall0 : tick0); // [R2]
  wire inc1 = go1 & (mode_reg[`DTC_BIT_SRC1] ? fall1 : tick1) &
              (mode1 != `DTC_MODE_SPLIT); // [R12] [R9]
  // split high byte: internal clock only, gating ignored
  wire inc0_high = split0 & run1_reg & tick0; // [R8]

  wire [16:0] step0 = dtc_step(mode0, t0_low_reg, t0_high_reg, inc0);
  wire [16:0] step1 = dtc_step(mode1, t1_low_reg, t1_high_reg, inc1);
  wire [8:0] split_high = {1'b0, t0_high_reg} + 9'h001;
  wire split_ovf = inc0_high & split_high[8];

  // overflow sources; split mode lends the timer 0 high byte to timer 1
  wire set0 = step0[16];
  wire set1 = step1[16] | split_ovf; // [R15]

  // next counts; a software write to a count byte wins over counting
  always @* begin
    t0_low_next = wr_t0l ? PWDATA_I[7:0] : step0[7:0];
    t0_high_next = step0[15:8];
    if (inc0_high) t0_high_next = split_high[7:0]; // [R8]
    if (wr_t0h) t0_high_next = PWDATA_I[7:0];
    t1_low_next = wr_t1l ? PWDATA_I[7:0] : step1[7:0];
    t1_high_next = wr_t1h ? PWDATA_I[7:0] : step1[15:8];
  end

  // flags: hardware set beats both software and vector clears
  always @* begin
    ovf0_next = TIMER0_OVERFLOW_FLAG_O;
    if (TIMER0_VECTOR_I) ovf0_next = 1'b0; // [R14]
    if (wr_run) ovf0_next = PWDATA_I[`DTC_BIT_OVF0]; // [R14]
    if (set0) ovf0_next = 1'b1; // [R14]
    ovf1_next = TIMER1_OVERFLOW_FLAG_O;
    if (TIMER1_VECTOR_I) ovf1_next = 1'b0; // [R14]
    if (wr_run) ovf1_next = PWDATA_I[`DTC_BIT_OVF1]; // [R14]
    if (set1) ovf1_next = 1'b1; // [R14] [R15]
  end

  // ****************************************
  // state update
  // ****************************************

  // software-owned setup bits
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_reg <= `DTC_RST_BYTE;
      prescale_reg <= `DTC_RST_BYTE;
      run0_reg <= 1'b0;
      run1_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= PWDATA_I[7:0]; // [R3]
      end
      // reserved prescale bits stay zero so a read shows only live bits
      if (wr_psc) begin
        prescale_reg <= PWDATA_I[7:0] & `DTC_PRESCALE_MASK;
      end
      if (wr_run) begin
        run0_reg <= PWDATA_I[`DTC_BIT_RUN0]; // [R13]
        run1_reg <= PWDATA_I[`DTC_BIT_RUN1]; // [R13]
      end
    end
  end

  // count bytes; the next values already carry the write-wins choice
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      t0_low_reg <= `DTC_RST_BYTE;
      t0_high_reg <= `DTC_RST_BYTE;
      t1_low_reg <= `DTC_RST_BYTE;
      t1_high_reg <= `DTC_RST_BYTE;
    end else begin
      t0_low_reg <= t0_low_next;
      t0_high_reg <= t0_high_next;
      t1_low_reg <= t1_low_next;
      t1_high_reg <= t1_high_next;
    end
  end

  // pin history; reset low so a pin idling high shows no fall at release
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt0_prev_reg <= 1'b0;
      cnt1_prev_reg <= 1'b0;
    end else begin
      cnt0_prev_reg <= COUNT_PIN_ZERO_I;
      cnt1_prev_reg <= COUNT_PIN_ONE_I;
    end
  end

  // flags feed the output pins straight from these flops
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TIMER0_OVERFLOW_FLAG_O <= 1'b0;
      TIMER1_OVERFLOW_FLAG_O <= 1'b0;
    end else begin
      TIMER0_OVERFLOW_FLAG_O <= ovf0_next;
      TIMER1_OVERFLOW_FLAG_O <= ovf1_next;
    end
  end
endmodule

/* tb/dtc_timer_chk_asserts.sv */
`timescale 1ns/1ps
module dtc_timer_chk (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire TIMER0_VECTOR_I,
  input wire TIMER1_VECTOR_I,
  input wire TIMER0_OVERFLOW_FLAG_O,
  input wire TIMER1_OVERFLOW_FLAG_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // exactly one wait state on every access
  property p_wait; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait");
  property p_src; PREADY_O |-> $past(PSEL_I && PENABLE_I && !PREADY_O); endproperty
  a_src: assert property (p_src) else $error("ready without access");
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; PSLVERR_O |-> PREADY_O; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdz; PSLVERR_O && !$past(PWRITE_I) |-> PRDATA_O == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("refused read not zero");
  property p_hi; PREADY_O |-> PRDATA_O[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  // read data only moves with an answer
  property p_hold; !PREADY_O |-> $stable(PRDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // a set can not land on two edges in a row, so a held vector wins once
  property p_vec0;
    (TIMER0_VECTOR_I && !PSEL_I) [*2] |-> (!TIMER0_OVERFLOW_FLAG_O or ##1 !TIMER0_OVERFLOW_FLAG_O);
  endproperty
  a_vec0: assert property (p_vec0) else $error("timer0 flag not cleared");
  // timer 1 has two set sources, so a held vector may need four edges
  property p_vec1;
    (TIMER1_VECTOR_I && !PSEL_I) [*4] |->
      ((!$past(TIMER1_OVERFLOW_FLAG_O, 2) || !$past(TIMER1_OVERFLOW_FLAG_O) ||
        !TIMER1_OVERFLOW_FLAG_O) or ##1 !TIMER1_OVERFLOW_FLAG_O);
  endproperty
  a_vec1: assert property (p_vec1) else $error("timer1 flag not cleared");
  c_err: cover property (PSLVERR_O);
  c_f0: cover property ($rose(TIMER0_OVERFLOW_FLAG_O));
  c_f1: cover property ($rose(TIMER1_OVERFLOW_FLAG_O));
endmodule
bind dtc_timer dtc_timer_chk u_chk (.*);

/* tb/dtc_pins.sv */
`timescale 1ns/1ps
// ****************************************
// count-pin source: bursts of falling edges
// ****************************************
module dtc_pins (
  input wire clk_i,
  input wire go_i,
  input wire sel_i,
  input wire [5:0] n_i,
  output logic [1:0] cnt_o,
  output logic busy_o
);
  logic [7:0] ph = 8'h00;
  wire lvl = ph[1] | (ph == 8'h00);
  // two cycles high, two low; idle high so the closing rise adds nothing
  always @(posedge clk_i) begin
    if (go_i) ph <= {n_i, 2'b00} - 8'h01;
    else if (ph != 8'h00) ph <= ph - 8'h01;
  end
  assign busy_o = (ph != 8'h00) | go_i;
  assign cnt_o = sel_i ? {lvl, 1'b1} : {1'b1, lvl};
endmodule

/* tb/tb_dtc_timer.sv */
`timescale 1ns/1ps
`include "dtc_consts.vh"
module tb_dtc_timer;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, sel = 0;
  logic [1:0] vec = 0, gate = 0;
  logic [5:0] n = 0;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [9:0] exq[$];
  logic [9:0] e;
  logic [7:0] r;
  wire [31:0] prdata;
  wire pready, pslverr, busy;
  wire [1:0] fl, cnt;
  int miscompares = 0, checks = 0, cyc = 0, t, k;
  always #20 clk = ~clk;
  dtc_timer DUT (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_IRQ_PIN_ZERO_I(gate[0]),
    .EXT_IRQ_PIN_ONE_I(gate[1]), .COUNT_PIN_ZERO_I(cnt[0]), .COUNT_PIN_ONE_I(cnt[1]),
    .TIMER0_VECTOR_I(vec[0]), .TIMER1_VECTOR_I(vec[1]),
    .TIMER0_OVERFLOW_FLAG_O(fl[0]), .TIMER1_OVERFLOW_FLAG_O(fl[1]));
  dtc_pins u_pins (.clk_i(clk), .go_i(go), .sel_i(sel), .n_i(n), .cnt_o(cnt), .busy_o(busy));
  task automatic chk(input string nm, input [31:0] ex, input [31:0] got);
    checks++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // apb master; the note of what to expect goes in first
  task automatic xf(input [9:0] a, input w, input [7:0] d, input [8:0] ex);
    exq.push_back({a[1:0] != 0 || a[9:2] < 8'h88 || a[9:2] > 8'h8E, ex});
    @(posedge clk);
    paddr <= a; pwr <= w; pwdata <= {24'h0, d}; psel <= 1; pen <= 0;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0; pen <= 0;
  endtask
  task automatic wr(input [7:0] i, input [7:0] d); xf({i, 2'b00}, 1, d, 9'h0); endtask
  task automatic rd(input [7:0] i, input [7:0] d); xf({i, 2'b00}, 0, 8'h0, {1'b1, d}); endtask
  task automatic burst(input s, input [5:0] c);
    sel <= s; n <= c; go <= 1;
    @(posedge clk) go <= 0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask
  // monitor: each answer takes the oldest note
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      stop_test();
    end else if (pready === 1'b1) begin
      if (exq.size() == 0) chk("answer", 0, 1);
      else begin
        e = exq.pop_front();
        chk("slverr", e[9], pslverr);
        if (e[8]) chk("rdata", {24'h0, e[7:0]}, prdata);
      end
    end
  end
  initial begin
    void'($urandom(53));
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 8'h88; i <= 8'h8E; i++) rd(i, 8'h0);
    xf(10'h23C, 0, 8'h0, 9'h100);
    xf(10'h221, 1, 8'hFF, 9'h0);
    for (int i = 8'h89; i <= 8'h8E; i++) begin
      r = $urandom;
      wr(i, r);
      rd(i, i == 8'h8E ? r & 8'h18 : r);
    end
    wr(8'h88, 8'hA0);
    vec <= 2'b11;
    repeat (4) @(posedge clk);
    vec <= 2'b00;
    rd(8'h88, 8'h0);
    // reload period: both timers, both dividers
    for (int p = 0; p < 4; p++) begin
      wr(8'h89, 8'h22);
      wr(8'h8E, {7'h00, p[1]} << (3 + p[0]));
      wr(8'h8C + p[0], 8'hFE);
      wr(8'h8A + p[0], 8'hFF);
      wr(8'h88, p[0] ? 8'h40 : 8'h10);
      while (fl[p[0]] !== 1'b1) @(posedge clk);
      vec[p[0]] <= 1;
      t = 0;
      do begin
        @(posedge clk);
        t++;
        vec <= 2'b00;
      end while (t < 3 || fl[p[0]] !== 1'b1);
      chk("period", 2 * (p[1] ? `DTC_DIV_FAST : `DTC_DIV_SLOW), t);
      wr(8'h88, 8'h0);
    end
    // gated pin counting, 16-bit
    for (int m = 0; m < 2; m++) begin
      wr(8'h89, m ? 8'hD0 : 8'h0D);
      wr(8'h8A + m, 8'h0);
      wr(8'h8C + m, 8'h0);
      wr(8'h88, m ? 8'h40 : 8'h10);
      burst(m, 1 + $urandom % 7);
      gate[m] <= 1;
      k = 1 + $urandom % 20;
      burst(m, k);
      gate <= 2'b00;
      wr(8'h88, 8'h0);
      rd(8'h8A + m, k[7:0]);
    end
    wr(8'h89, 8'h04);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    burst(0, 1);
    rd(8'h8A, 8'hE0);
    rd(8'h8C, 8'h00);
    rd(8'h88, 8'h30);
    wr(8'h88, 8'h0);
    // split mode
    wr(8'h89, 8'h77);
    wr(8'h8A, 8'h0);
    wr(8'h8B, 8'h5A);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h50);
    burst(0, 3);
    burst(1, 2);
    rd(8'h88, 8'hD0);
    rd(8'h8A, 8'h03);
    rd(8'h8B, 8'h5A);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
